/* File: logic/ecf_pkg.sv */
/*
 * Constants shared by the client-side frame FIFO pair.
 * Assumes one clock for both the user ports and the MAC client side.
 */
// Contract
// - A byte moves only when source-ready and destination-ready are both low.
// - The source marks first byte with start-of-frame, last with end-of-frame.
// - Transmit and receive FIFOs are separate and run independently in one wrapper.
// - Each FIFO uses two dual-port RAM blocks holding 4096 bytes.
// - Frames the MAC marks good are presented on the receive port.
// - Frames the MAC marks bad never appear on the receive port.
// - Receive port has its own clock, synchronous reset and 8-bit output data; here it runs on REF_CLK.
// - Transmit port has its own clock, reset, 8-bit data, framing and ready; here it runs on REF_CLK.
// - A frame goes to the MAC only once it is wholly stored.
// - After the first byte, wait for acknowledge, then stream the rest.
// - On collision the current transmit frame stops.
// - Collision with retransmit keeps the frame and resends it from byte one.
// - Full transmit memory drops destination-ready until space frees.
// - Receive overflow drops the current frame and flags receive overflow.
// - After overflow, frames are dropped until reads free memory.
// - A 4-bit transmit status shows memory fill.
// - Full transmit memory with no whole frame flags overflow, drains, drops frame.
package ecf_pkg;
    localparam int ADDR_W     = 12;
    localparam int PTR_W      = 13;
    localparam int BANK_AW    = 11;
    localparam int BYTE_W     = 8;
    localparam int WORD_W     = 9;
    localparam int LAST_BIT   = 8;
    localparam int STATUS_W   = 4;
    localparam int STATUS_LSB = 8;
    localparam logic [PTR_W-1:0]    DEPTH       = 13'h1000;
    localparam logic [PTR_W-1:0]    PTR_ONE     = 13'h0001;
    localparam logic [PTR_W-1:0]    PTR_ZERO    = 13'h0000;
    localparam logic [STATUS_W-1:0] STATUS_FULL = 4'hF;
    localparam int FRM_W = 13;

    typedef enum logic [2:0] {
        XS_IDLE     = 3'b000,
        XS_PREP     = 3'b001,
        XS_WAIT_ACK = 3'b010,
        XS_STREAM   = 3'b011,
        XS_DRAIN    = 3'b100
    } ecf_xmt_state_e;
endpackage : ecf_pkg

/* File: logic/ecf_dpram.sv */
/*
 * One simple dual-port RAM block with registered read data.
 * Assumes write and read share one clock.
 */
`timescale 1ns/1ps
module ecf_dpram #(
    parameter int AW = 11,
    parameter int W  = 9
) (
    // Clock and reset
    input  wire logic          clk,
    input  wire logic          rst_n,
    // Write port
    input  wire logic          we,
    input  wire logic [AW-1:0] waddr,
    input  wire logic [W-1:0]  wdata,
    // Read port
    input  wire logic          re,
    input  wire logic [AW-1:0] raddr,
    output logic      [W-1:0]  rdata
);
    logic [W-1:0] mem [0:(1<<AW)-1];

    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    // Read data holds while re is low, so a stalled reader sees stable bytes.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata <= '0;
        end else if (re) begin
            rdata <= mem[raddr];
        end
    end
endmodule : ecf_dpram

/* File: logic/ecf_fifo_mem.sv */
/*
 * Frame memory of one FIFO: two RAM blocks split on the top address bit.
 * Assumes the caller never reads and writes past its own pointers.
 */
`timescale 1ns/1ps
module ecf_fifo_mem (
    // Clock and reset
    input  wire logic                         clk,
    input  wire logic                         rst_n,
    // Write port
    input  wire logic                         we,
    input  wire logic [ecf_pkg::ADDR_W-1:0]   waddr,
    input  wire logic [ecf_pkg::WORD_W-1:0]   wdata,
    // Read port
    input  wire logic                         re,
    input  wire logic [ecf_pkg::ADDR_W-1:0]   raddr,
    output logic      [ecf_pkg::WORD_W-1:0]   rdata
);
    logic                       sel_q;
    logic [ecf_pkg::WORD_W-1:0] bank_data [0:1];

    genvar b;
    generate
        for (b = 0; b < 2; b++) begin : g_bank
            ecf_dpram #(.AW(ecf_pkg::BANK_AW), .W(ecf_pkg::WORD_W)) u_ram (
                .clk   (clk),
                .rst_n (rst_n),
                .we    (we && (waddr[ecf_pkg::ADDR_W-1] == 1'(b))),
                .waddr (waddr[ecf_pkg::BANK_AW-1:0]),
                .wdata (wdata),
                .re    (re && (raddr[ecf_pkg::ADDR_W-1] == 1'(b))),
                .raddr (raddr[ecf_pkg::BANK_AW-1:0]),
                .rdata (bank_data[b])
            );
        end
    endgenerate

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sel_q <= 1'b0;
        end else if (re) begin
            sel_q <= raddr[ecf_pkg::ADDR_W-1];
        end
    end

    assign rdata = bank_data[sel_q];
endmodule : ecf_fifo_mem

/* File: logic/ecf_top.sv */
/*
 * Client-side frame FIFO pair between a MAC client interface and user logic.
 * Assumes all ports, user and MAC, run on REF_CLK; MAC good/bad strobes
 * arrive after the last data-valid byte of a frame.
 */
`timescale 1ns/1ps
module ecf_top (
    // Clock and reset
    input  wire logic                              REF_CLK,
    input  wire logic                              RESET_N,
    // MAC receive client side
    input  wire logic [ecf_pkg::BYTE_W-1:0]        MAC_RX_DATA,
    input  wire logic                              MAC_RX_DATA_VALID,
    input  wire logic                              MAC_RX_GOOD_FRAME,
    input  wire logic                              MAC_RX_BAD_FRAME,
    // Receive user port
    input  wire logic                              RCV_PORT_SYNC_RST,
    output logic      [ecf_pkg::BYTE_W-1:0]        RCV_PORT_BYTE_OUT,
    output logic                                   RCV_PORT_FIRST_LOW,
    output logic                                   RCV_PORT_LAST_LOW,
    output logic                                   RCV_PORT_VALID_LOW,
    input  wire logic                              RCV_PORT_ACCEPT_LOW,
    output logic                                   RX_OVERFLOW,
    // Transmit user port
    input  wire logic                              XMT_PORT_SYNC_RST,
    input  wire logic [ecf_pkg::BYTE_W-1:0]        XMT_PORT_BYTE_IN,
    input  wire logic                              XMT_PORT_FIRST_LOW,
    input  wire logic                              XMT_PORT_LAST_LOW,
    input  wire logic                              XMT_PORT_VALID_LOW,
    output logic                                   XMT_PORT_ACCEPT_LOW,
    output logic      [ecf_pkg::STATUS_W-1:0]      XMT_FIFO_STATUS,
    output logic                                   TX_OVERFLOW,
    // MAC transmit client side
    output logic      [ecf_pkg::BYTE_W-1:0]        MAC_TX_DATA,
    output logic                                   MAC_TX_DATA_VALID,
    input  wire logic                              MAC_TX_ACK,
    input  wire logic                              MAC_TX_COLLISION,
    input  wire logic                              MAC_TX_RETRANSMIT
);
    // ------------------------------------------------------------------
    // Receive FIFO
    // ------------------------------------------------------------------
    logic [ecf_pkg::PTR_W-1:0]  rw_q;
    logic [ecf_pkg::PTR_W-1:0]  rs_q;
    logic [ecf_pkg::PTR_W-1:0]  rr_q;
    logic [ecf_pkg::PTR_W-1:0]  ovf_mark_q;
    logic [ecf_pkg::BYTE_W-1:0] pend_q;
    logic                       pend_v_q;
    logic                       in_frame_q;
    logic                       drop_q;
    logic                       frame_drop_q;
    logic                       rv_q;
    logic                       first_q;
    logic                       rovf_q;
    logic [ecf_pkg::WORD_W-1:0] r_rdata;
    logic                       r_full;
    logic                       r_wr_req;
    logic                       r_ovf_hit;
    logic                       r_we;
    logic                       r_commit;
    logic                       r_end;
    logic                       r_take;
    logic                       r_issue;

    // A byte is parked in pend_q until the next byte or the status strobe
    // tells whether it was the last one; only then is it written with its flag.
    assign r_full    = (rw_q - rr_q) == ecf_pkg::DEPTH;
    assign r_end     = MAC_RX_GOOD_FRAME || MAC_RX_BAD_FRAME;
    assign r_wr_req  = pend_v_q && !frame_drop_q && (MAC_RX_DATA_VALID || MAC_RX_GOOD_FRAME);
    assign r_ovf_hit = r_wr_req && r_full;
    assign r_we      = r_wr_req && !r_full;
    assign r_commit  = MAC_RX_GOOD_FRAME && r_we;
    assign r_take    = rv_q && !RCV_PORT_ACCEPT_LOW;
    assign r_issue   = (rr_q != rs_q) && (!rv_q || r_take);

    ecf_fifo_mem u_rx_mem (
        .clk   (REF_CLK),
        .rst_n (RESET_N),
        .we    (r_we),
        .waddr (rw_q[ecf_pkg::ADDR_W-1:0]),
        .wdata ({MAC_RX_GOOD_FRAME, pend_q}),
        .re    (r_issue),
        .raddr (rr_q[ecf_pkg::ADDR_W-1:0]),
        .rdata (r_rdata)
    );

    always_ff @(posedge REF_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            pend_q     <= '0;
            pend_v_q   <= 1'b0;
            in_frame_q <= 1'b0;
        end else if (RCV_PORT_SYNC_RST) begin
            pend_v_q   <= 1'b0;
            in_frame_q <= 1'b0;
        end else if (r_end) begin
            pend_v_q   <= 1'b0;
            in_frame_q <= 1'b0;
        end else if (MAC_RX_DATA_VALID) begin
            pend_q     <= MAC_RX_DATA;
            pend_v_q   <= 1'b1;
            in_frame_q <= 1'b1;
        end
    end

    // Write pointer and commit pointer; a bad or dropped frame rewinds.
    always_ff @(posedge REF_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            rw_q <= ecf_pkg::PTR_ZERO;
            rs_q <= ecf_pkg::PTR_ZERO;
        end else if (RCV_PORT_SYNC_RST) begin
            rw_q <= ecf_pkg::PTR_ZERO;
            rs_q <= ecf_pkg::PTR_ZERO;
        end else if (r_commit) begin
            rw_q <= rw_q + ecf_pkg::PTR_ONE;
            rs_q <= rw_q + ecf_pkg::PTR_ONE;
        end else if (r_ovf_hit || r_end) begin
            rw_q <= rs_q;
        end else if (r_we) begin
            rw_q <= rw_q + ecf_pkg::PTR_ONE;
        end
    end

    // Drop state lasts until the reader has moved since the overflow, or nothing is
    // left to read, so an overflow into an empty memory cannot lock the receiver up.
    always_ff @(posedge REF_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            drop_q       <= 1'b0;
            frame_drop_q <= 1'b0;
            ovf_mark_q   <= ecf_pkg::PTR_ZERO;
            rovf_q       <= 1'b0;
        end else if (RCV_PORT_SYNC_RST) begin
            drop_q       <= 1'b0;
            frame_drop_q <= 1'b0;
            rovf_q       <= 1'b0;
        end else begin
            rovf_q <= r_ovf_hit;
            if (r_ovf_hit) begin
                drop_q       <= 1'b1;
                frame_drop_q <= 1'b1;
                ovf_mark_q   <= rr_q;
            end else begin
                if (r_end) begin
                    frame_drop_q <= 1'b0;
                end else if (MAC_RX_DATA_VALID && !in_frame_q) begin
                    frame_drop_q <= drop_q;
                end
                if (drop_q && !in_frame_q && ((rr_q != ovf_mark_q) || (rr_q == rs_q))) begin
                    drop_q <= 1'b0;
                end
            end
        end
    end

    // Read side: RAM read data is the output register and holds while stalled.
    always_ff @(posedge REF_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            rr_q    <= ecf_pkg::PTR_ZERO;
            rv_q    <= 1'b0;
            first_q <= 1'b1;
        end else if (RCV_PORT_SYNC_RST) begin
            rr_q    <= ecf_pkg::PTR_ZERO;
            rv_q    <= 1'b0;
            first_q <= 1'b1;
        end else begin
            if (r_issue) begin
                rr_q <= rr_q + ecf_pkg::PTR_ONE;
            end
            rv_q <= r_issue || (rv_q && !r_take);
            if (r_take) begin
                first_q <= r_rdata[ecf_pkg::LAST_BIT];
            end
        end
    end

    assign RCV_PORT_BYTE_OUT  = r_rdata[ecf_pkg::BYTE_W-1:0];
    assign RCV_PORT_VALID_LOW = !rv_q;
    assign RCV_PORT_FIRST_LOW = !(rv_q && first_q);
    assign RCV_PORT_LAST_LOW  = !(rv_q && r_rdata[ecf_pkg::LAST_BIT]);
    assign RX_OVERFLOW        = rovf_q;

    // ------------------------------------------------------------------
    // Transmit FIFO, user side
    // ------------------------------------------------------------------
    logic [ecf_pkg::PTR_W-1:0] tw_q;
    logic [ecf_pkg::PTR_W-1:0] ts_q;
    logic [ecf_pkg::PTR_W-1:0] tb_q;
    logic [ecf_pkg::PTR_W-1:0] tr_q;
    logic [ecf_pkg::FRM_W-1:0] tfr_q;
    logic                      tovf_q;
    logic [ecf_pkg::PTR_W-1:0] t_used;
    logic                      t_full;
    logic                      t_accept;
    logic                      t_take;
    logic                      t_we;
    logic                      t_last;
    logic                      t_commit;
    logic                      t_done;

    // Pointers share one clock here, so fill is a plain difference and no
    // crossing is needed; a split-clock build would carry gray pointers.
    assign t_used   = tw_q - tb_q;
    assign t_full   = t_used == ecf_pkg::DEPTH;
    assign t_accept = !t_full || tovf_q;
    assign t_take   = !XMT_PORT_VALID_LOW && t_accept;
    assign t_we     = t_take && !tovf_q;
    assign t_last   = t_take && !XMT_PORT_LAST_LOW;
    assign t_commit = t_last && !tovf_q;

    assign XMT_PORT_ACCEPT_LOW = !t_accept;
    assign TX_OVERFLOW         = tovf_q;
    assign XMT_FIFO_STATUS     = t_used[ecf_pkg::ADDR_W] ? ecf_pkg::STATUS_FULL
                               : t_used[ecf_pkg::ADDR_W-1:ecf_pkg::STATUS_LSB];

    always_ff @(posedge REF_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            tw_q   <= ecf_pkg::PTR_ZERO;
            ts_q   <= ecf_pkg::PTR_ZERO;
            tovf_q <= 1'b0;
        end else if (XMT_PORT_SYNC_RST) begin
            tw_q   <= ecf_pkg::PTR_ZERO;
            ts_q   <= ecf_pkg::PTR_ZERO;
            tovf_q <= 1'b0;
        end else if (t_last && tovf_q) begin
            tw_q   <= ts_q;
            tovf_q <= 1'b0;
        end else if (t_commit) begin
            tw_q <= tw_q + ecf_pkg::PTR_ONE;
            ts_q <= tw_q + ecf_pkg::PTR_ONE;
        end else if (t_we) begin
            tw_q <= tw_q + ecf_pkg::PTR_ONE;
        end else if (t_full && (tfr_q == '0) && !tovf_q) begin
            tovf_q <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Transmit FIFO, MAC side
    // ------------------------------------------------------------------
    ecf_pkg::ecf_xmt_state_e   xs_q;
    logic [ecf_pkg::WORD_W-1:0] t_rdata;
    logic                       t_re;
    logic [ecf_pkg::PTR_W-1:0]  t_raddr;
    logic                       t_is_last;
    logic                       t_coll;
    logic                       t_adv;

    assign t_is_last = t_rdata[ecf_pkg::LAST_BIT];
    assign t_coll    = MAC_TX_COLLISION && ((xs_q == ecf_pkg::XS_WAIT_ACK) || (xs_q == ecf_pkg::XS_STREAM));
    assign t_adv     = !t_coll && !t_is_last && (((xs_q == ecf_pkg::XS_WAIT_ACK) && MAC_TX_ACK)
                     || (xs_q == ecf_pkg::XS_STREAM) || (xs_q == ecf_pkg::XS_DRAIN));
    assign t_done    = !t_coll && t_is_last && (((xs_q == ecf_pkg::XS_WAIT_ACK) && MAC_TX_ACK)
                     || (xs_q == ecf_pkg::XS_STREAM) || (xs_q == ecf_pkg::XS_DRAIN));
    assign t_re      = ((xs_q == ecf_pkg::XS_IDLE) && (tfr_q != '0)) || t_adv;
    assign t_raddr   = (xs_q == ecf_pkg::XS_IDLE) ? tr_q : tr_q + ecf_pkg::PTR_ONE;

    ecf_fifo_mem u_tx_mem (
        .clk   (REF_CLK),
        .rst_n (RESET_N),
        .we    (t_we),
        .waddr (tw_q[ecf_pkg::ADDR_W-1:0]),
        .wdata ({!XMT_PORT_LAST_LOW, XMT_PORT_BYTE_IN}),
        .re    (t_re),
        .raddr (t_raddr[ecf_pkg::ADDR_W-1:0]),
        .rdata (t_rdata)
    );

    always_ff @(posedge REF_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            xs_q <= ecf_pkg::XS_IDLE;
        end else if (XMT_PORT_SYNC_RST) begin
            xs_q <= ecf_pkg::XS_IDLE;
        end else begin
            unique case (xs_q)
                ecf_pkg::XS_IDLE: begin
                    if (tfr_q != '0) begin
                        xs_q <= ecf_pkg::XS_PREP;
                    end
                end
                ecf_pkg::XS_PREP: begin
                    xs_q <= ecf_pkg::XS_WAIT_ACK;
                end
                ecf_pkg::XS_WAIT_ACK, ecf_pkg::XS_STREAM: begin
                    if (t_coll) begin
                        xs_q <= MAC_TX_RETRANSMIT ? ecf_pkg::XS_IDLE : ecf_pkg::XS_DRAIN;
                    end else if (t_done) begin
                        xs_q <= ecf_pkg::XS_IDLE;
                    end else if (t_adv) begin
                        xs_q <= ecf_pkg::XS_STREAM;
                    end
                end
                ecf_pkg::XS_DRAIN: begin
                    if (t_done) begin
                        xs_q <= ecf_pkg::XS_IDLE;
                    end
                end
                default: begin
                    xs_q <= ecf_pkg::XS_IDLE;
                end
            endcase
        end
    end

    // The frame base stays put until a frame ends, so a retransmit can rewind.
    always_ff @(posedge REF_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            tr_q <= ecf_pkg::PTR_ZERO;
            tb_q <= ecf_pkg::PTR_ZERO;
        end else if (XMT_PORT_SYNC_RST) begin
            tr_q <= ecf_pkg::PTR_ZERO;
            tb_q <= ecf_pkg::PTR_ZERO;
        end else if (t_coll && MAC_TX_RETRANSMIT) begin
            tr_q <= tb_q;
        end else if (t_done) begin
            tr_q <= tr_q + ecf_pkg::PTR_ONE;
            tb_q <= tr_q + ecf_pkg::PTR_ONE;
        end else if (t_adv) begin
            tr_q <= tr_q + ecf_pkg::PTR_ONE;
        end
    end

    always_ff @(posedge REF_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            tfr_q <= '0;
        end else if (XMT_PORT_SYNC_RST) begin
            tfr_q <= '0;
        end else begin
            tfr_q <= tfr_q + FRM_INC(t_commit) - FRM_INC(t_done);
        end
    end

    function automatic logic [ecf_pkg::FRM_W-1:0] FRM_INC(input logic b);
        FRM_INC = {{(ecf_pkg::FRM_W-1){1'b0}}, b};
    endfunction : FRM_INC

    assign MAC_TX_DATA       = t_rdata[ecf_pkg::BYTE_W-1:0];
    assign MAC_TX_DATA_VALID = (xs_q == ecf_pkg::XS_WAIT_ACK) || (xs_q == ecf_pkg::XS_STREAM);

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    a_rx_bad_drop: assert property (@(posedge REF_CLK) disable iff (!RESET_N || RCV_PORT_SYNC_RST)
        MAC_RX_BAD_FRAME |=> $stable(rs_q)) else $error("bad frame moved commit pointer");
    a_rx_good_commit: assert property (@(posedge REF_CLK) disable iff (!RESET_N || RCV_PORT_SYNC_RST)
        r_commit |=> rs_q == $past(rw_q) + ecf_pkg::PTR_ONE) else $error("good frame not committed");
    a_rx_hold_out: assert property (@(posedge REF_CLK) disable iff (!RESET_N || RCV_PORT_SYNC_RST)
        (rv_q && RCV_PORT_ACCEPT_LOW) |=> (!RCV_PORT_VALID_LOW && $stable(RCV_PORT_BYTE_OUT)))
        else $error("receive output changed while stalled");
    a_rx_ovf_flag: assert property (@(posedge REF_CLK) disable iff (!RESET_N || RCV_PORT_SYNC_RST)
        r_ovf_hit |=> (RX_OVERFLOW && rw_q == $past(rs_q))) else $error("overflow not flagged");
    a_rx_drop_keep: assert property (@(posedge REF_CLK) disable iff (!RESET_N || RCV_PORT_SYNC_RST)
        (drop_q && rr_q == ovf_mark_q && rr_q != rs_q) |=> drop_q) else $error("drop ended before read");
    a_tx_full_stall: assert property (@(posedge REF_CLK) disable iff (!RESET_N || XMT_PORT_SYNC_RST)
        (t_full && !tovf_q) |-> XMT_PORT_ACCEPT_LOW) else $error("accepted while full");
    a_tx_whole_frame: assert property (@(posedge REF_CLK) disable iff (!RESET_N || XMT_PORT_SYNC_RST)
        (xs_q == ecf_pkg::XS_IDLE && tfr_q == '0) |=> xs_q == ecf_pkg::XS_IDLE) else $error("sent partial frame");
    a_tx_wait_ack: assert property (@(posedge REF_CLK) disable iff (!RESET_N || XMT_PORT_SYNC_RST)
        (xs_q == ecf_pkg::XS_WAIT_ACK && !MAC_TX_ACK && !MAC_TX_COLLISION)
        |=> (xs_q == ecf_pkg::XS_WAIT_ACK && $stable(MAC_TX_DATA))) else $error("left wait without ack");
    a_tx_coll_stop: assert property (@(posedge REF_CLK) disable iff (!RESET_N || XMT_PORT_SYNC_RST)
        t_coll |=> !MAC_TX_DATA_VALID [*2]) else $error("sent after collision");
    a_tx_retx_rewind: assert property (@(posedge REF_CLK) disable iff (!RESET_N || XMT_PORT_SYNC_RST)
        (t_coll && MAC_TX_RETRANSMIT) |=> (tr_q == $past(tb_q) && tfr_q == $past(tfr_q) + FRM_INC($past(t_commit))))
        else $error("retransmit lost frame");
    a_tx_ovf_flag: assert property (@(posedge REF_CLK) disable iff (!RESET_N || XMT_PORT_SYNC_RST)
        (t_full && tfr_q == '0 && !(tovf_q && t_last)) |=> TX_OVERFLOW ##0 !XMT_PORT_ACCEPT_LOW)
        else $error("overflow not flagged");
endmodule : ecf_top

/* File: test/ecf_mac_model.sv */
/*
 * MAC transmit client model: acknowledges the first byte after a set delay.
 * Assumes the FIFO holds each frame's first byte until acknowledge.
 */
`timescale 1ns/1ps
module ecf_mac_model (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst_n,
    // Client side of the FIFO
    input  wire logic       vld,
    input  wire logic [3:0] dly,
    input  wire logic [1:0] crq,
    output logic            ack,
    output logic            col,
    output logic            rtx,
    output logic            tk
);
    logic       acked_q;
    logic       hit_q;
    logic [3:0] cnt_q;
    // One collision per armed frame, raised before acknowledge so no byte is half taken.
    assign tk  = vld && (ack || acked_q);
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ack     <= 1'b0;
            acked_q <= 1'b0;
            hit_q   <= 1'b0;
            col     <= 1'b0;
            rtx     <= 1'b0;
            cnt_q   <= 4'h0;
        end else begin
            ack   <= 1'b0;
            col   <= 1'b0;
            hit_q <= hit_q && crq[0];
            if (!vld) begin
                acked_q <= 1'b0;
                cnt_q   <= 4'h0;
            end else if (ack) begin
                acked_q <= 1'b1;
            end else if (crq[0] && !hit_q) begin
                col   <= 1'b1;
                rtx   <= crq[1];
                hit_q <= 1'b1;
            end else if (!acked_q && !col) begin
                cnt_q <= cnt_q + 4'h1;
                ack   <= (cnt_q == dly);
            end
        end
    end
endmodule : ecf_mac_model

/* File: test/ecf_tb_top.sv */
/*
 * Self-checking bench: MAC frames in, user frames out, and the reverse.
 * Assumes every port runs on the one reference clock.
 */
`timescale 1ns/1ps
module ecf_tb_top;
    logic       clk = 1'b0, rst_n = 1'b0, mv = 1'b0, mg = 1'b0, mb = 1'b0, ra_n = 1'b0;
    logic       xv_n = 1'b1, xf_n = 1'b1, xl_n = 1'b1, ack, col, rtx, tk, rv_n, rf_n, rl_n, rxo, xa_n, mtv, txo;
    logic [7:0] md = 8'h00, xd = 8'h00, rd, mtd;
    logic [3:0] st, dly = 4'h0;
    logic [1:0] crq = 2'b00;
    logic       hold = 1'b0, srst = 1'b0;
    logic [31:0] lf = 32'hD4A8E482, lr = 32'hD4A8E482;
    logic [9:0] rxq[$];
    logic [7:0] txq[$];
    int         num_errors = 0, compares = 0, ovc = 0, tvc = 0;
    function automatic logic [31:0] nx(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : nx
    initial forever #5 clk = ~clk;
    ecf_top dut (.REF_CLK(clk), .RESET_N(rst_n), .MAC_RX_DATA(md), .MAC_RX_DATA_VALID(mv),
        .MAC_RX_GOOD_FRAME(mg), .MAC_RX_BAD_FRAME(mb), .RCV_PORT_SYNC_RST(srst), .RCV_PORT_BYTE_OUT(rd),
        .RCV_PORT_FIRST_LOW(rf_n), .RCV_PORT_LAST_LOW(rl_n), .RCV_PORT_VALID_LOW(rv_n),
        .RCV_PORT_ACCEPT_LOW(ra_n), .RX_OVERFLOW(rxo), .XMT_PORT_SYNC_RST(srst), .XMT_PORT_BYTE_IN(xd),
        .XMT_PORT_FIRST_LOW(xf_n), .XMT_PORT_LAST_LOW(xl_n), .XMT_PORT_VALID_LOW(xv_n),
        .XMT_PORT_ACCEPT_LOW(xa_n), .XMT_FIFO_STATUS(st), .TX_OVERFLOW(txo), .MAC_TX_DATA(mtd),
        .MAC_TX_DATA_VALID(mtv), .MAC_TX_ACK(ack), .MAC_TX_COLLISION(col), .MAC_TX_RETRANSMIT(rtx));
    ecf_mac_model mac (.clk(clk), .rst_n(rst_n), .vld(mtv), .dly(dly), .crq(crq), .ack(ack), .col(col),
        .rtx(rtx), .tk(tk));
    task automatic chk(input string nm, input logic [9:0] e, input logic [9:0] g);
        compares++;
        if (g !== e) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic drain();
        for (int w = 0; w < 5000 && (rxq.size() || txq.size() || mtv); w++) @(posedge clk);
        @(negedge clk);
    endtask : drain
    // ----------------------------------------
    // Stimulus
    // ----------------------------------------
    task automatic rx_frame(input int n, input logic good);
        for (int i = 0; i < n; i++) begin
            @(negedge clk);
            lf = nx(lf);
            mv = 1'b1;
            md = lf[15:8];
            if (good) rxq.push_back({i != 0, i != n - 1, md});
        end
        @(negedge clk);
        mv = 1'b0;
        @(negedge clk);
        {mg, mb} = {good, !good};
        @(negedge clk);
        {mg, mb} = 2'b00;
    endtask : rx_frame
    task automatic tx_frame(input int n);
        logic alone;
        alone = (txq.size() == 0) && (mtv === 1'b0);
        for (int i = 0; i < n; i++) begin
            @(negedge clk);
            lf = nx(lf);
            {xv_n, xd, xf_n, xl_n} = {1'b0, lf[23:16], i != 0, i != n - 1};
            txq.push_back(xd);
            @(posedge clk);
            while (xa_n !== 1'b0) @(posedge clk);
            if (alone) chk("tx early", 10'h000, {9'h000, mtv});
        end
        @(negedge clk);
        xv_n = 1'b1;
    endtask : tx_frame
    // Reader stalls about a quarter of cycles so held bytes are checked too.
    always @(negedge clk) begin
        lr = nx(lr);
        ra_n <= (lr[0] & lr[1]) | hold;
    end
    always @(posedge clk) begin
        if (rst_n && rv_n === 1'b0 && ra_n === 1'b0) begin
            if (rxq.size() == 0) chk("rx extra", ~{rf_n, rl_n, rd}, {rf_n, rl_n, rd});
            else chk("rx byte", rxq.pop_front(), {rf_n, rl_n, rd});
        end
        if (tk === 1'b1) chk("tx byte", {2'b00, txq.size() ? txq.pop_front() : ~mtd}, {2'b00, mtd});
        if (rxo === 1'b1) ovc++;
        if (txo === 1'b1) begin
            tvc++;
            chk("tx status full", 10'h00F, {6'h00, st});
        end
    end
    task automatic close_out();
        num_errors += rxq.size() + txq.size();
        $display("compares %0d num_errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : close_out
    initial begin
        #300000;
        num_errors++;
        $display("[ERR] watchdog expected done seen hang");
        close_out();
    end
    initial begin
        repeat (10) @(posedge clk);
        @(negedge clk);
        rst_n = 1'b1;
        chk("idle", 10'h070, {3'b000, rv_n, rf_n, rl_n, xa_n, mtv, rxo, txo});
        for (int k = 0; k < 6; k++) rx_frame(2 + k * 7, k != 2);
        $display("test rx done");
        for (int k = 0; k < 5; k++) begin
            dly = 4'(k * 3);
            tx_frame(3 + k * 9);
        end
        $display("test tx done");
        for (int c = 1; c < 4; c += 2) begin
            drain();
            crq = 2'(c);
            tx_frame(12);
            if (c == 1) txq.delete();
            repeat (60) @(negedge clk);
            crq = 2'b00;
        end
        drain();
        tx_frame(4100);
        txq.delete();
        chk("tx overflow", 10'h004, 10'(tvc));
        hold = 1'b1;
        rx_frame(9, 1'b1);
        rx_frame(4100, 1'b0);
        rx_frame(5, 1'b1);
        repeat (5) void'(rxq.pop_back());
        hold = 1'b0;
        repeat (30) @(negedge clk);
        rx_frame(6, 1'b1);
        chk("rx overflow", 10'h001, 10'(ovc));
        $display("test overflow done");
        drain();
        hold = 1'b1;
        rx_frame(7, 1'b1);
        srst = 1'b1;
        @(negedge clk);
        srst = 1'b0;
        repeat (7) void'(rxq.pop_back());
        chk("sync reset", 10'h070, {3'b000, rv_n, rf_n, rl_n, xa_n, mtv, rxo, txo});
        hold = 1'b0;
        $display("test reset done");
        drain();
        chk("status", 10'h000, {6'h00, st});
        close_out();
    end
endmodule : ecf_tb_top
